/* hdl/hbcm_consts.vh */
`ifndef HBCM_CONSTS_VH
`define HBCM_CONSTS_VH
// access-type selector encodings
`define HBCM_ACC_ANY 2'h0
`define HBCM_ACC_EXEC 2'h1
`define HBCM_ACC_DMA 2'h2
`define HBCM_ACC_VECT 2'h3
// bus-cycle class encodings on the cycle-type input
`define HBCM_CYC_FETCH 2'h0
`define HBCM_CYC_EXEC 2'h1
`define HBCM_CYC_DMA 2'h2
`define HBCM_CYC_VECT 2'h3
// interrupt-level lines sit in the low nibble of the one-byte setting
`define HBCM_LVL_LSB 0
`define HBCM_LVL_WIDTH 4
// counter widths and reset values
`define HBCM_SAT_WIDTH 16
`define HBCM_DLY_WIDTH 15
`define HBCM_CNT_RST 16'h0000
`define HBCM_DLY_RST 15'h0000
// the delay counter exists on this channel only
`define HBCM_DELAY_CHANNEL 7
`endif

/* hdl/hbcm_sync2.v */
`include "hbcm_consts.vh"
module hbcm_sync2 #(
  parameter WIDTH = 1
) (
  // clocking
  input wire clock,
  input wire sys_rst,
  input wire clk_en,
  // data
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  always @(posedge clock) begin
    if (sys_rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule

/* hdl/hbcm_addr_match.v */
`include "hbcm_consts.vh"
module hbcm_addr_match #(
  parameter AW = 32
) (
  // bus address
  input wire [AW-1:0] bus_addr,
  // settings
  input wire addr_en,
  input wire range_en,
  input wire [AW-1:0] addr_lo,
  input wire [AW-1:0] addr_hi,
  input wire [AW-1:0] addr_mask,
  // result
  output wire addr_hit
);
  // ---------------------------------------------
  // masked compare: a set mask bit forces a match
  // ---------------------------------------------
  wire [AW-1:0] keep = ~addr_mask;
  wire [AW-1:0] a = bus_addr & keep;
  wire [AW-1:0] lo = addr_lo & keep;
  wire [AW-1:0] hi = addr_hi & keep;
  wire eq_hit = (a == lo);
  wire rng_hit = (a >= lo) && (a <= hi);

  assign addr_hit = ~addr_en | (range_en ? rng_hit : eq_hit);
endmodule

/* hdl/hbcm_top.v */
// What this block does
// - NMI matches when low for low level, when high for high level, always for no level.
// - Four interrupt-level lines each compared with its own setting bit.
// - Each interrupt-level bit can be masked to always match.
// - Satisfaction count 1..65535: fire after conditions met that many times.
// - Delay count 1..32767: fire that many bus cycles after satisfaction.
// - Delay counter exists on channel seven only; others ignore delay.
// - Single address: condition met when bus address equals it.
// - Lower and upper address: met when address inside inclusive range.
// - Masked address bits do not affect the address match.
// - Access type selects one class, or none letting all cycles qualify.
// - Masks apply per bit, so masked bits always satisfy the compare.
`include "hbcm_consts.vh"
module hbcm_top #(
  parameter AW = 32,
  parameter CHANNEL = 7
) (
  // clocking
  input wire clock,
  input wire sys_rst,
  input wire clk_en,
  // target bus, same clock domain
  input wire bus_cycle_valid,
  input wire [AW-1:0] bus_addr,
  input wire [1:0] bus_cycle_type,
  // interrupt pins, asynchronous
  input wire nmi_pin,
  input wire [3:0] interrupt_level_lines,
  // address settings
  input wire addr_en,
  input wire range_en,
  input wire [AW-1:0] addr_lo,
  input wire [AW-1:0] addr_hi,
  input wire [AW-1:0] addr_mask,
  // access type setting
  input wire [1:0] acc_sel,
  // interrupt settings
  input wire nmi_en,
  input wire nmi_high,
  input wire lvl_en,
  input wire [7:0] lvl_value,
  input wire [7:0] lvl_mask,
  // counts
  input wire [15:0] sat_count,
  input wire [14:0] delay_count,
  // restart of counters, break acknowledge
  input wire arm_clear,
  // status
  output reg break_req,
  output reg [15:0] sat_seen,
  output reg [14:0] delay_seen
);
  // ---------------------------------------------
  // qualification states
  // ---------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_FIRED = 2'h2;

  // ---------------------------------------------
  // registers and next values
  // ---------------------------------------------
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [15:0] sat_ff;
  reg [15:0] nxt_sat;
  reg [14:0] dly_ff;
  reg [14:0] nxt_dly;

  // ---------------------------------------------
  // pin synchronisation
  // ---------------------------------------------
  wire [4:0] pins_s;
  hbcm_sync2 #(.WIDTH(5)) u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .async_in({nmi_pin, interrupt_level_lines}),
    .sync_out(pins_s)
  );
  wire nmi_s = pins_s[4];
  wire [3:0] lvl_s = pins_s[3:0];

  // ---------------------------------------------
  // address condition
  // ---------------------------------------------
  wire addr_ok;
  hbcm_addr_match #(.AW(AW)) u_addr (
    .bus_addr(bus_addr),
    .addr_en(addr_en),
    .range_en(range_en),
    .addr_lo(addr_lo),
    .addr_hi(addr_hi),
    .addr_mask(addr_mask),
    .addr_hit(addr_ok)
  );

  // ---------------------------------------------
  // access type, interrupt conditions
  // ---------------------------------------------
  reg acc_ok;
  always @* begin
    case (acc_sel)
      `HBCM_ACC_EXEC: acc_ok = (bus_cycle_type == `HBCM_CYC_EXEC);
      `HBCM_ACC_DMA: acc_ok = (bus_cycle_type == `HBCM_CYC_DMA);
      `HBCM_ACC_VECT: acc_ok = (bus_cycle_type == `HBCM_CYC_VECT);
      default: acc_ok = 1'b1;
    endcase
  end

  reg nmi_ok;
  always @* begin
    if (!nmi_en) begin
      nmi_ok = 1'b1;
    end else if (nmi_high) begin
      nmi_ok = nmi_s;
    end else begin
      nmi_ok = ~nmi_s;
    end
  end

  wire [3:0] lvl_bit_ok;
  genvar gi;
  generate
    for (gi = 0; gi < `HBCM_LVL_WIDTH; gi = gi + 1) begin : g_lvl
      // masked bit matches whatever its level
      assign lvl_bit_ok[gi] = lvl_mask[`HBCM_LVL_LSB + gi] |
        (lvl_s[gi] == lvl_value[`HBCM_LVL_LSB + gi]);
    end
  endgenerate
  wire lvl_ok = ~lvl_en | (&lvl_bit_ok);

  // ---------------------------------------------
  // combined condition
  // ---------------------------------------------
  wire cond_hit = bus_cycle_valid & addr_ok & acc_ok & nmi_ok & lvl_ok;
  // hits are only taken while armed and idle
  wire take_hit = (state_ff == ST_IDLE) && cond_hit;

  // ---------------------------------------------
  // satisfaction count
  // ---------------------------------------------
  wire sat_used = (sat_count != `HBCM_CNT_RST);
  wire [15:0] sat_inc = sat_ff + 16'h0001;
  wire sat_done = ~sat_used | (sat_inc >= sat_count);

  always @* begin
    nxt_sat = sat_ff;
    if (arm_clear) begin
      nxt_sat = `HBCM_CNT_RST;
    end else if (take_hit && sat_used) begin
      nxt_sat = sat_inc;
    end
  end

  // ---------------------------------------------
  // delay count
  // ---------------------------------------------
  wire dly_allowed = (CHANNEL == `HBCM_DELAY_CHANNEL);
  wire dly_used = dly_allowed && (delay_count != `HBCM_DLY_RST);
  wire [14:0] dly_inc = dly_ff + 15'h0001;
  wire dly_done = (dly_inc >= delay_count);

  always @* begin
    nxt_dly = dly_ff;
    if (arm_clear) begin
      nxt_dly = `HBCM_DLY_RST;
    end else if (take_hit && sat_done && dly_used) begin
      nxt_dly = `HBCM_DLY_RST;
    end else if ((state_ff == ST_DELAY) && bus_cycle_valid) begin
      nxt_dly = dly_inc;
    end
  end

  // ---------------------------------------------
  // qualification state machine
  // ---------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (take_hit && sat_done) begin
          if (dly_used) begin
            nxt_state = ST_DELAY;
          end else begin
            nxt_state = ST_FIRED;
          end
        end
      end
      ST_DELAY: begin
        if (bus_cycle_valid && dly_done) begin
          nxt_state = ST_FIRED;
        end
      end
      ST_FIRED: begin
        nxt_state = ST_FIRED;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // a clear wins over a hit in the same cycle
    if (arm_clear) begin
      nxt_state = ST_IDLE;
    end
  end

  wire nxt_break = (nxt_state == ST_FIRED);

  // ---------------------------------------------
  // state registers
  // ---------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_IDLE;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      sat_ff <= `HBCM_CNT_RST;
      dly_ff <= `HBCM_DLY_RST;
    end else if (clk_en) begin
      sat_ff <= nxt_sat;
      dly_ff <= nxt_dly;
    end
  end

  // ---------------------------------------------
  // output registers
  // ---------------------------------------------
  always @(posedge clock) begin
    if (sys_rst) begin
      break_req <= 1'b0;
    end else if (clk_en) begin
      break_req <= nxt_break;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      sat_seen <= `HBCM_CNT_RST;
      delay_seen <= `HBCM_DLY_RST;
    end else if (clk_en) begin
      sat_seen <= nxt_sat;
      delay_seen <= nxt_dly;
    end
  end
endmodule

/* tb/hbcm_props.sv */
module hbcm_props(
  // clocking
  input wire clock, sys_rst, clk_en,
  // bus and settings
  input wire bus_cycle_valid, addr_en, range_en, nmi_en, lvl_en, arm_clear,
  input wire [31:0] bus_addr, addr_lo, addr_hi, addr_mask,
  input wire [1:0] bus_cycle_type, acc_sel,
  input wire [15:0] sat_count,
  input wire [14:0] delay_count,
  // status
  input wire break_req,
  input wire [15:0] sat_seen,
  input wire [14:0] delay_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // a cycle that could raise the break on the next edge
  wire q = clk_en && bus_cycle_valid && !break_req && !arm_clear && delay_count == 0;
  wire [31:0] d = (bus_addr ^ addr_lo) & ~addr_mask;
  hold_break_a: assert property (break_req && !arm_clear |=> break_req)
    else $error("break dropped");
  clear_break_a: assert property (clk_en && arm_clear |=> !break_req)
    else $error("break not cleared");
  addr_miss_a: assert property (q && addr_en && !range_en && d != 0 |=> !break_req)
    else $error("break on other address");
  range_miss_a: assert property (q && addr_en && range_en && addr_mask == 0
    && (bus_addr < addr_lo || bus_addr > addr_hi) |=> !break_req) else $error("out of range");
  acc_miss_a: assert property (q && acc_sel != 0 && bus_cycle_type != acc_sel
    |=> !break_req) else $error("wrong cycle class");
  mask_hit_a: assert property (q && addr_en && !range_en && d == 0 && acc_sel == 0
    && !nmi_en && !lvl_en && sat_count == 0 |=> break_req) else $error("masked miss");
  sat_fire_a: assert property ($rose(break_req) && sat_count != 0
    && delay_count == 0 |-> sat_seen == sat_count) else $error("count off");
  delay_fire_a: assert property ($rose(break_req) && delay_count != 0
    |-> delay_seen == delay_count) else $error("delay off");
  cover property ($rose(break_req) && sat_count != 0);
  cover property ($rose(break_req) && delay_count != 0);
  cover property ($rose(break_req) && acc_sel != 0);
endmodule
bind hbcm_top hbcm_props u_props(.*);

/* tb/hbcm_cpu.sv */
module hbcm_cpu(
  input wire clock,
  output logic bus_cycle_valid = 0,
  output logic [31:0] bus_addr = 0,
  output logic [1:0] bus_cycle_type = 0,
  output logic nmi_pin = 1,
  output logic [3:0] interrupt_level_lines = 0
);
  timeunit 1ns;
  timeprecision 100ps;
  // one bus cycle; the released address lines then show the inverse
  task automatic cyc(input logic [31:0] a, input logic [1:0] t);
    @(posedge clock) #1;
    bus_cycle_valid = 1;
    bus_addr = a;
    bus_cycle_type = t;
    @(posedge clock) #1;
    bus_cycle_valid = 0;
    bus_addr = ~a;
    bus_cycle_type = ~t;
  endtask
endmodule

/* tb/hbcm_top_tb.sv */
module hbcm_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 0, sys_rst = 1, clk_en = 1, addr_en = 0, range_en = 0, arm_clear = 0;
  logic nmi_en = 0, nmi_high = 0, lvl_en = 0;
  logic [31:0] addr_lo = 0, addr_hi = 0, addr_mask = 0;
  logic [1:0] acc_sel = 0;
  logic [7:0] lvl_value = 0, lvl_mask = 0;
  logic [15:0] sat_count = 0;
  logic [14:0] delay_count = 0;
  wire bus_cycle_valid, nmi_pin, break_req;
  wire [31:0] bus_addr;
  wire [1:0] bus_cycle_type;
  wire [3:0] interrupt_level_lines;
  wire [15:0] sat_seen;
  wire [14:0] delay_seen;
  int n_errors = 0, checks = 0;
  always #2.5 clock = ~clock;
  hbcm_cpu cpu(.*);
  hbcm_top u_hbcm_top(.*);
  task chk(input logic [31:0] s, e, input string n);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask
  task hit(input logic [31:0] a, input logic [1:0] t, input logic e);
    cpu.cyc(a, t);
    chk(break_req, e, "break_req");
  endtask
  task clr;
    arm_clear = 1;
    @(posedge clock) #1;
    arm_clear = 0;
  endtask
  // pins pass a two-flop synchroniser
  task pins(input logic n, input logic [3:0] l);
    cpu.nmi_pin = n;
    cpu.interrupt_level_lines = l;
    repeat (3) @(posedge clock);
  endtask
  task close_out;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge clock);
    #1 sys_rst = 0;
    addr_en = 1;
    addr_lo = 32'h100;
    addr_hi = 32'h1ff;
    hit(32'h104, 0, 0);
    hit(32'h100, 0, 1);
    clr;
    addr_mask = 32'hf;
    hit(32'h10c, 0, 1);
    clr;
    hit(32'h110, 0, 0);
    addr_mask = 0;
    range_en = 1;
    hit(32'h200, 0, 0);
    hit(32'h1ff, 0, 1);
    clr;
    hit(32'hff, 0, 0);
    range_en = 0;
    for (int s = 1; s < 4; s++) begin
      acc_sel = s[1:0];
      hit(32'h100, s[1:0] ^ 2'h1, 0);
      hit(32'h100, s[1:0], 1);
      clr;
    end
    acc_sel = 0;
    $display("test address and type done");
    nmi_en = 1;
    hit(32'h100, 0, 0);
    pins(0, 0);
    hit(32'h100, 0, 1);
    clr;
    nmi_high = 1;
    hit(32'h100, 0, 0);
    pins(1, 0);
    hit(32'h100, 0, 1);
    clr;
    nmi_en = 0;
    lvl_en = 1;
    lvl_value = 8'h05;
    pins(1, 4'h4);
    hit(32'h100, 0, 0);
    pins(1, 4'h5);
    hit(32'h100, 0, 1);
    clr;
    lvl_mask = 8'h01;
    pins(1, 4'h4);
    hit(32'h100, 0, 1);
    clr;
    lvl_en = 0;
    $display("test interrupt lines done");
    sat_count = 16'h3;
    hit(32'h100, 1, 0);
    hit(32'h100, 1, 0);
    chk(sat_seen, 2, "sat_seen");
    hit(32'h100, 1, 1);
    chk(sat_seen, 3, "sat_seen");
    clr;
    sat_count = 0;
    delay_count = 15'h2;
    hit(32'h100, 1, 0);
    hit(32'h300, 1, 0);
    hit(32'h300, 1, 1);
    chk(delay_seen, 2, "delay_seen");
    clr;
    delay_count = 0;
    clk_en = 0;
    hit(32'h100, 1, 0);
    clk_en = 1;
    hit(32'h100, 1, 1);
    sys_rst = 1;
    @(posedge clock) #1;
    sys_rst = 0;
    chk(break_req, 0, "break_req");
    hit(32'h100, 1, 1);
    clr;
    $display("test counts done");
    close_out;
  end
endmodule
